// *** verilog/asp_consts.svh ***
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH

// ----------------------------------------------------------------
// Widths of the memory port and of the wait timer count
// ----------------------------------------------------------------
`define ASP_ADDR_W          13
`define ASP_DATA_W          8
`define ASP_CNT_W           3

// ----------------------------------------------------------------
// Clock and least memory times, in ns
// ----------------------------------------------------------------
`define ASP_CLK_PERIOD_NS   50
`define ASP_T_RC_FAST_NS    100
`define ASP_T_RC_SLOW_NS    120
`define ASP_T_WP_FAST_NS    60
`define ASP_T_WP_SLOW_NS    70
`define ASP_T_CW_FAST_NS    80
`define ASP_T_CW_SLOW_NS    85

// Least time rounded up to whole clock cycles
`define ASP_CYC_MIN(ns)     (((ns) + `ASP_CLK_PERIOD_NS - 1) / `ASP_CLK_PERIOD_NS)
`define ASP_MAX(a, b)       (((a) > (b)) ? (a) : (b))

// Strobe-active cycles: read access equals read cycle time
`define ASP_RD_FAST_CYC     `ASP_CYC_MIN(`ASP_T_RC_FAST_NS)
`define ASP_RD_SLOW_CYC     `ASP_CYC_MIN(`ASP_T_RC_SLOW_NS)
`define ASP_WR_FAST_CYC     `ASP_CYC_MIN(`ASP_MAX(`ASP_T_WP_FAST_NS, `ASP_T_CW_FAST_NS))
`define ASP_WR_SLOW_CYC     `ASP_CYC_MIN(`ASP_MAX(`ASP_T_WP_SLOW_NS, `ASP_T_CW_SLOW_NS))

// ----------------------------------------------------------------
// Pin patterns {chipSelectN, chipSelectHi, outputGateN, writeStrobeN}
// ----------------------------------------------------------------
`define ASP_PINS_IDLE       4'b1011
`define ASP_PINS_READ       4'b0101
`define ASP_PINS_WRITE      4'b0110
`define ASP_PINS_HOLD_SELN  4'b1110
`define ASP_PINS_HOLD_SELHI 4'b0010
`define ASP_PINS_HOLD_STRB  4'b0111

`define ASP_ADDR_RST        13'h0000
`define ASP_DATA_RST        8'h00
`define ASP_CNT_ONE         3'h1
`define ASP_CNT_ZERO        3'h0

`endif

// *** verilog/asp_pkg.sv ***
package asp_pkg;

  // ----------------------------------------------------------------
  // Controller sequence states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SETUP  = 4'b0010,
    ST_ACTIVE = 4'b0100,
    ST_END    = 4'b1000
  } asp_state_e;

  // ----------------------------------------------------------------
  // Which pin carries the write pulse
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    WM_SEL_N  = 3'b001,
    WM_SEL_HI = 3'b010,
    WM_STROBE = 3'b100
  } asp_wmode_e;

  typedef logic [3:0] asp_pins_t;

endpackage

// *** verilog/asp_wait_timer.sv ***
`timescale 1ns/1ps
`include "asp_consts.svh"

// Down counter that times how long the strobes stay asserted
module asp_wait_timer
  import asp_pkg::*;
(
  // Clocking
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  // Control
  input  wire logic                  load,
  input  wire logic [`ASP_CNT_W-1:0] loadValue,
  // Status
  output logic                       lastCycle
);

  logic [`ASP_CNT_W-1:0] count;

  // Load wins; otherwise count down and rest at zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= `ASP_CNT_ZERO;
    end else if (ce) begin
      if (load) begin
        count <= loadValue;
      end else if (count != `ASP_CNT_ZERO) begin
        count <= count - `ASP_CNT_ONE;
      end
    end
  end

  // High in the final cycle of the timed window
  assign lastCycle = (count == `ASP_CNT_ONE);

endmodule

// *** verilog/asp_sram_host.sv ***
`timescale 1ns/1ps
`include "asp_consts.svh"

// How it works
// - Keep write strobe high during reads
// - Select-low write: hold others, pulse select-low
// - Select-high write: hold others, pulse select-high
// - Strobe write: hold selects, pulse write strobe
// - Read select and gate held 100 or 150 ns (two or three cycles)
// - Write overlap 100 ns (two cycles) in both grades
module asp_sram_host
  import asp_pkg::*;
(
  // Clocking and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   ce,
  // Configuration
  input  wire logic                   gradeSlow,
  input  wire asp_wmode_e             writeMode,
  // Request side
  input  wire logic                   reqValid,
  input  wire logic                   reqWrite,
  input  wire logic [`ASP_ADDR_W-1:0] reqAddr,
  input  wire logic [`ASP_DATA_W-1:0] reqData,
  output logic                        reqReady,
  // Answer side
  output logic                        rspValid,
  output logic [`ASP_DATA_W-1:0]      rspData,
  // Memory control pins
  output logic                        chipSelectN,
  output logic                        chipSelectHi,
  output logic                        outputGateN,
  output logic                        writeStrobeN,
  // Memory address and data pins
  output logic [`ASP_ADDR_W-1:0]      addrBus,
  input  wire logic [`ASP_DATA_W-1:0] dataPinsIn,
  output logic [`ASP_DATA_W-1:0]      dataPinsOut,
  output logic                        dataPinsOe
);

  // ----------------------------------------------------------------
  // Pin pattern decode
  // ----------------------------------------------------------------

  // Strobe levels for a state of the sequence; held pins stay put
  // through setup and end so only one pin makes the pulse
  function automatic asp_pins_t pinLevels(input asp_state_e st,
                                          input logic       isWrite,
                                          input asp_wmode_e mode);
    asp_pins_t pins;
    pins = `ASP_PINS_IDLE;
    if (st == ST_ACTIVE) begin
      // Read keeps strobe high, write keeps gate high
      pins = isWrite ? `ASP_PINS_WRITE : `ASP_PINS_READ;
    end else if (isWrite && (st == ST_SETUP || st == ST_END)) begin
      unique case (mode)
        WM_SEL_N:  pins = `ASP_PINS_HOLD_SELN;
        WM_SEL_HI: pins = `ASP_PINS_HOLD_SELHI;
        WM_STROBE: pins = `ASP_PINS_HOLD_STRB;
        default:   pins = `ASP_PINS_IDLE;
      endcase
    end
    return pins;
  endfunction

  // Strobe-active length for the latched grade and direction
  function automatic logic [`ASP_CNT_W-1:0] activeCycles(input logic slow,
                                                         input logic isWrite);
    logic [`ASP_CNT_W-1:0] n;
    if (isWrite) begin
      n = slow ? `ASP_CNT_W'(`ASP_WR_SLOW_CYC) : `ASP_CNT_W'(`ASP_WR_FAST_CYC);
    end else begin
      n = slow ? `ASP_CNT_W'(`ASP_RD_SLOW_CYC) : `ASP_CNT_W'(`ASP_RD_FAST_CYC);
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // State and request holding registers
  // ----------------------------------------------------------------

  asp_state_e            state;
  asp_state_e            next_state;
  logic                  curWrite;
  logic                  curSlow;
  asp_wmode_e            curMode;
  logic                  lastCycle;
  logic                  accept;
  logic                  timerLoad;
  asp_pins_t             next_pins;

  // Only take a new request from idle
  assign reqReady  = (state == ST_IDLE);
  assign accept    = reqReady && reqValid && ce;
  assign timerLoad = (state == ST_SETUP);

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------

  // Setup, strobe window, one release cycle, then idle again
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:   if (reqValid) next_state = ST_SETUP;
      ST_SETUP:  next_state = ST_ACTIVE;
      ST_ACTIVE: if (lastCycle) next_state = ST_END;
      ST_END:    next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Strobe window timer; the count covers the memory's least time
  asp_wait_timer u_timer (
    .clk       (clk),
    .resetn    (resetn),
    .ce        (ce),
    .load      (timerLoad),
    .loadValue (activeCycles(curSlow, curWrite)),
    .lastCycle (lastCycle)
  );

  // ----------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------

  // Latch direction, grade and mode so a mid-cycle change is harmless
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      curWrite <= 1'b0;
      curSlow  <= 1'b0;
      curMode  <= WM_STROBE;
    end else if (accept) begin
      curWrite <= reqWrite;
      curSlow  <= gradeSlow;
      curMode  <= writeMode;
    end
  end

  // Address held from setup until the next accept
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addrBus <= `ASP_ADDR_RST;
    end else if (accept) begin
      addrBus <= reqAddr;
    end
  end

  // ----------------------------------------------------------------
  // Control pins
  // ----------------------------------------------------------------

  // Pins are registered from the next state, so no glitches reach them
  assign next_pins = pinLevels(next_state, accept ? reqWrite : curWrite,
                               accept ? writeMode : curMode);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chipSelectN  <= 1'b1;
      chipSelectHi <= 1'b0;
      outputGateN  <= 1'b1;
      writeStrobeN <= 1'b1;
    end else if (ce) begin
      // Idle pattern deselects; memory then ignores the other pins
      {chipSelectN, chipSelectHi, outputGateN, writeStrobeN} <= next_pins;
    end
  end

  // ----------------------------------------------------------------
  // Data pins
  // ----------------------------------------------------------------

  // Drive only on writes; the gate stays high then, so the memory
  // output floats and the bus never sees two drivers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dataPinsOut <= `ASP_DATA_RST;
      dataPinsOe  <= 1'b0;
    end else if (ce) begin
      if (accept) begin
        dataPinsOut <= reqData;
        dataPinsOe  <= reqWrite;
      end else if (state == ST_END) begin
        // Data held past the end of the overlap, then released
        dataPinsOe  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------

  // Sample at the edge closing the window, a full access time after
  // select, gate and address were all valid
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rspValid <= 1'b0;
      rspData  <= `ASP_DATA_RST;
    end else if (ce) begin
      rspValid <= 1'b0;
      if (state == ST_ACTIVE && lastCycle && !curWrite) begin
        rspValid <= 1'b1;
        rspData  <= dataPinsIn;
      end
    end
  end

endmodule

// *** verif/asp_sram_host_props.sv ***
`timescale 1ns/1ps
`include "asp_consts.svh"
// Pin-level checks on the memory host
module asp_sram_host_props (
  // Clocking and grade
  input wire logic                   clk,
  input wire logic                   resetn,
  input wire logic                   gradeSlow,
  // Memory pins and answer
  input wire logic                   chipSelectN,
  input wire logic                   chipSelectHi,
  input wire logic                   outputGateN,
  input wire logic                   writeStrobeN,
  input wire logic [`ASP_ADDR_W-1:0] addrBus,
  input wire logic                   dataPinsOe,
  input wire logic                   rspValid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------
  // Decoded memory modes
  // ----------
  logic rd;
  logic wr;
  assign rd = !chipSelectN && chipSelectHi && !outputGateN;
  assign wr = !chipSelectN && chipSelectHi && !writeStrobeN;

  property p_rdStrobe; rd |-> writeStrobeN; endproperty
  a_rdStrobe: assert property (p_rdStrobe) else $error("strobe low in read");
  property p_rdFast; $rose(rd) |-> rd[*2]; endproperty
  a_rdFast: assert property (p_rdFast) else $error("read window short");
  property p_rdSlow; $rose(rd) && gradeSlow |-> rd[*3]; endproperty
  a_rdSlow: assert property (p_rdSlow) else $error("slow read window short");
  property p_wrPulse; $rose(wr) |-> wr[*2]; endproperty
  a_wrPulse: assert property (p_wrPulse) else $error("write pulse short");
  // One pin opens the overlap, the other two were already held
  property p_wrOneEdge;
    $rose(wr) |-> $countones({$changed(chipSelectN), $changed(chipSelectHi),
                              $changed(writeStrobeN)}) == 1;
  endproperty
  a_wrOneEdge: assert property (p_wrOneEdge) else $error("write not one pulse");
  property p_wrAddr; wr |-> $stable(addrBus); endproperty
  a_wrAddr: assert property (p_wrAddr) else $error("address moved in write");
  property p_wrDrive; wr |-> dataPinsOe && outputGateN; endproperty
  a_wrDrive: assert property (p_wrDrive) else $error("write data not driven");
  property p_rsp; $rose(rspValid) |-> $past(rd) && !rd; endproperty
  a_rsp: assert property (p_rsp) else $error("answer without read window");
endmodule

// *** verif/asp_sram_model.sv ***
`timescale 1ns/1ps
// Behavioural static memory on the far side of the pins
module asp_sram_model (
  // Control pins from the host
  input wire logic        csN,
  input wire logic        csHi,
  input wire logic        gateN,
  input wire logic        strobeN,
  // Address and data
  input wire logic [12:0] addr,
  input wire logic [7:0]  busIn,
  output logic [7:0]      busOut
);
  logic [7:0] mem [0:8191];
  logic [7:0] last;
  wire sel = !csN && csHi;
  wire wrOn = sel && !strobeN;
  wire drv = sel && !gateN && strobeN;
  // Latch at the end of the overlap, whichever pin ends it
  always @(negedge wrOn) mem[addr] = busIn;
  // Floating pins show the inverse, never a stale match
  always @* begin
    if (drv) last = mem[addr];
    busOut = drv ? mem[addr] : ~last;
  end
endmodule

// *** verif/asp_sram_host_tb.sv ***
`timescale 1ns/1ps
`include "asp_consts.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module asp_sram_host_tb
  import asp_pkg::*;
;
  // ----------
  // Bench signals
  // ----------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic gradeSlow = 1'b0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  asp_wmode_e writeMode = WM_STROBE;
  logic [12:0] reqAddr = 13'h0000;
  logic [7:0] reqData = 8'h00;
  logic reqReady, rspValid, chipSelectN, chipSelectHi, outputGateN, writeStrobeN, dataPinsOe;
  logic [12:0] addrBus;
  logic [7:0] rspData, dataPinsOut, memOut, dataBus;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  // Host drive wins the wire, otherwise the memory
  assign dataBus = dataPinsOe ? dataPinsOut : memOut;
  asp_sram_host dut_u (.clk(clk), .resetn(resetn), .ce(ce), .gradeSlow(gradeSlow),
    .writeMode(writeMode), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
    .chipSelectN(chipSelectN), .chipSelectHi(chipSelectHi), .outputGateN(outputGateN),
    .writeStrobeN(writeStrobeN), .addrBus(addrBus), .dataPinsIn(dataBus),
    .dataPinsOut(dataPinsOut), .dataPinsOe(dataPinsOe));
  asp_sram_model mem_u (.csN(chipSelectN), .csHi(chipSelectHi), .gateN(outputGateN),
    .strobeN(writeStrobeN), .addr(addrBus), .busIn(dataBus), .busOut(memOut));
  // Clock and hang guard
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude();
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // One request; lat is cycles from accept to answer or ready
  task automatic xfer(input logic w, input asp_wmode_e m, input logic g,
                      input logic [12:0] a, input logic [7:0] d, input int lat);
    int n;
    @(negedge clk);
    reqValid = 1'b1;
    reqWrite = w;
    writeMode = m;
    gradeSlow = g;
    reqAddr = a;
    reqData = d;
    @(negedge clk);
    reqValid = 1'b0;
    n = 1;
    while (!(w ? reqReady : rspValid) && n < 20) begin
      @(negedge clk);
      n++;
    end
    `CHK(n, lat)
    if (!w) `CHK(rspData, d)
  endtask
  task automatic s_resetIdle();
    `CHK({chipSelectN, chipSelectHi, outputGateN, writeStrobeN}, `ASP_PINS_IDLE)
    `CHK({dataPinsOe, reqReady, rspValid}, 3'b010)
  endtask
  task automatic s_writeModes();
    asp_wmode_e m[3] = '{WM_SEL_N, WM_SEL_HI, WM_STROBE};
    logic [12:0] a[3] = '{13'h0000, 13'h1FFF, 13'h0AAA};
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, m[i], 1'b0, a[i], 8'hA5 ^ i[7:0], 5);
    end
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, WM_STROBE, 1'b0, a[i], 8'hA5 ^ i[7:0], 4);
    end
  endtask
  task automatic s_grades();
    xfer(1'b1, WM_STROBE, 1'b1, 13'h1FFF, 8'h3C, 5);
    xfer(1'b0, WM_SEL_N, 1'b1, 13'h1FFF, 8'h3C, 5);
    xfer(1'b0, WM_SEL_N, 1'b1, 13'h0000, 8'hA5, 5);
  endtask
  // Clock enable low in mid-read freezes pins and timer
  task automatic s_freeze();
    int n;
    @(negedge clk);
    reqValid = 1'b1;
    reqWrite = 1'b0;
    gradeSlow = 1'b0;
    reqAddr = 13'h1FFF;
    @(negedge clk);
    reqValid = 1'b0;
    @(negedge clk);
    ce = 1'b0;
    repeat (3) @(negedge clk);
    `CHK({chipSelectN, chipSelectHi, outputGateN, writeStrobeN}, `ASP_PINS_READ)
    `CHK({reqReady, rspValid}, 2'b00)
    ce = 1'b1;
    n = 0;
    while (!rspValid && n < 20) begin
      @(negedge clk);
      n++;
    end
    `CHK(n, 2)
    `CHK(rspData, 8'h3C)
  endtask
  // Reset in mid-read drops the pins at once and loses the answer
  task automatic s_midReset();
    @(negedge clk);
    reqValid = 1'b1;
    reqWrite = 1'b0;
    gradeSlow = 1'b0;
    reqAddr = 13'h0AAA;
    @(negedge clk);
    reqValid = 1'b0;
    @(negedge clk);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    `CHK({chipSelectN, chipSelectHi, outputGateN, writeStrobeN}, `ASP_PINS_IDLE)
    `CHK({dataPinsOe, reqReady, rspValid}, 3'b010)
    resetn = 1'b1;
    xfer(1'b0, WM_STROBE, 1'b0, 13'h0AAA, 8'hA7, 4);
  endtask
  initial begin
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    s_resetIdle();
    s_writeModes();
    s_grades();
    s_freeze();
    s_midReset();
    conclude();
  end
endmodule
bind asp_sram_host asp_sram_host_props props_u (.clk(clk), .resetn(resetn),
  .gradeSlow(gradeSlow), .chipSelectN(chipSelectN), .chipSelectHi(chipSelectHi),
  .outputGateN(outputGateN), .writeStrobeN(writeStrobeN), .addrBus(addrBus),
  .dataPinsOe(dataPinsOe), .rspValid(rspValid));
